// File: src/phy_regs_pkg.sv
// Package for the PHY identification and advertisement register bank.
// Assumes a 32-bit AXI4-Lite register bus; registers sit in the low 16 bits.
package phy_regs_pkg;

    localparam int ADDR_W = 8;

    // Register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_BASIC_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_VENDOR_ID_HIGH = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_VENDOR_ID_LOW = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_AUTONEG_ADVERT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_BASIC_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_VENDOR_ID_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_VENDOR_ID_LOW = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_AUTONEG_ADVERT = 8'h10;

    // Field positions
    localparam int EXT_CAP_BIT = 0;
    localparam int ADV_NEXT_PAGE_BIT = 15;
    localparam int ADV_RSVD14_BIT = 14;
    localparam int ADV_REMOTE_FAULT_BIT = 13;
    localparam int ADV_EXT_NEXT_PAGE_BIT = 12;
    localparam int ADV_ASYM_PAUSE_BIT = 11;
    localparam int ADV_SYM_PAUSE_BIT = 10;
    localparam int ADV_RSVD9_BIT = 9;
    localparam int ADV_100_FD_BIT = 8;
    localparam int ADV_100_HD_BIT = 7;
    localparam int ADV_10_FD_BIT = 6;
    localparam int ADV_10_HD_BIT = 5;

    // Writable advertisement bits; reserved 14 and 9 are excluded
    localparam logic [15:0] ADV_WRITE_MASK = 16'hBDFF;
    localparam logic [15:0] ADV_RESET = 16'h0101;
    localparam logic [15:0] BASIC_STATUS_VALUE = 16'h0001;

    // Arbitrary neutral identity values, build parameters
    localparam logic [15:0] VENDOR_ID_HIGH_RESET = 16'h1234;
    localparam logic [5:0] VENDOR_ID_LOW_BITS_RESET = 6'h15;
    localparam logic [5:0] MODEL_RESET = 6'h2A;
    localparam logic [3:0] REVISION_RESET = 4'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [5:0] oui_bits;
        logic [5:0] model;
        logic [3:0] revision;
    } id_low_s;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic [1:0] wstrb;
    } reg_req_s;

endpackage : phy_regs_pkg

// File: src/phy_reg_file.sv
// Register storage for the identification and advertisement registers.
// Assumes one request per enabled cycle from the bus slave above it.
`timescale 1ns/1ps
`default_nettype none
module phy_reg_file
    import phy_regs_pkg::*;
#(
    parameter logic [3:0] REVISION = REVISION_RESET
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Request
    input wire logic req_valid,
    input wire phy_regs_pkg::reg_req_s req,
    // Answer
    output logic [15:0] rd_data,
    output logic hit,
    // Advertised abilities
    output logic [15:0] advert
);
    import phy_regs_pkg::*;

    logic [15:0] id_high_q, id_high_d;
    id_low_s id_low_q, id_low_d;
    logic [15:0] adv_q, adv_d;
    logic [15:0] wmask;

    assign wmask = {{8{req.wstrb[1]}}, {8{req.wstrb[0]}}};

    always_comb
    begin
        id_high_d = id_high_q;
        id_low_d = id_low_q;
        adv_d = adv_q;
        if (req_valid && req.wr)
        begin
            if (req.addr == ADDR_VENDOR_ID_HIGH)
            begin
                id_high_d = (id_high_q & ~wmask) | (req.wdata & wmask);
            end
            else if (req.addr == ADDR_VENDOR_ID_LOW)
            begin
                id_low_d = (id_low_q & ~wmask) | (req.wdata & wmask);
            end
            else if (req.addr == ADDR_AUTONEG_ADVERT)
            begin
                // Reserved bits never stored
                adv_d = (adv_q & ~(wmask & ADV_WRITE_MASK))
                      | (req.wdata & wmask & ADV_WRITE_MASK);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            id_high_q <= VENDOR_ID_HIGH_RESET;
            id_low_q <= {VENDOR_ID_LOW_BITS_RESET, MODEL_RESET, REVISION_RESET};
            adv_q <= ADV_RESET;
        end
        else if (clk_en)
        begin
            id_high_q <= id_high_d;
            id_low_q <= id_low_d;
            adv_q <= adv_d;
        end
    end

    // Revision restored from the build parameter on the first enabled cycle is avoided:
    // the parameter feeds the read path only until software writes the field.
    logic rev_written_q, rev_written_d;
    always_comb
    begin
        rev_written_d = rev_written_q;
        if (req_valid && req.wr && req.addr == ADDR_VENDOR_ID_LOW && req.wstrb[0])
        begin
            rev_written_d = 1'b1;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rev_written_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rev_written_q <= rev_written_d;
        end
    end

    always_comb
    begin
        rd_data = 16'h0000;
        hit = 1'b1;
        if (req.addr == ADDR_BASIC_STATUS)
        begin
            rd_data = BASIC_STATUS_VALUE;
        end
        else if (req.addr == ADDR_VENDOR_ID_HIGH)
        begin
            rd_data = id_high_q;
        end
        else if (req.addr == ADDR_VENDOR_ID_LOW)
        begin
            rd_data = {id_low_q.oui_bits, id_low_q.model,
                       rev_written_q ? id_low_q.revision : REVISION};
        end
        else if (req.addr == ADDR_AUTONEG_ADVERT)
        begin
            rd_data = adv_q & ADV_WRITE_MASK;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    assign advert = adv_q;

endmodule : phy_reg_file
`default_nettype wire

// File: src/phy_id_and_autoneg_advert_regs.sv
// AXI4-Lite slave holding the PHY identification and advertisement registers.
// Assumes a well-behaved AXI4-Lite master, one clock, synchronous reset.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module phy_id_and_autoneg_advert_regs
    import phy_regs_pkg::*;
#(
    parameter logic [3:0] REVISION = REVISION_RESET
)
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Write address
    input wire logic [phy_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address
    input wire logic [phy_regs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Advertised abilities toward the negotiation engine
    output logic [15:0] advert_q
);
    import phy_regs_pkg::*;

    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [1:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;
    logic [15:0] advert_d;

    logic do_write, do_read;
    reg_req_s req;
    logic [15:0] rf_rd_data;
    logic rf_hit;
    logic [15:0] rf_advert;

    // Write fires once both halves are held and the response slot is free
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    // Reads only when no write uses the shared register port
    assign do_read = s_axi_arvalid && arready_q && !do_write;

    always_comb
    begin
        req.wr = do_write;
        req.addr = do_write ? awaddr_q : s_axi_araddr;
        req.wdata = wdata_q;
        req.wstrb = wstrb_q;
    end

    phy_reg_file #(
        .REVISION(REVISION)
    ) u_reg_file (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .req_valid(do_write),
        .req(req),
        .rd_data(rf_rd_data),
        .hit(rf_hit),
        .advert(rf_advert)
    );

    // Write channel
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata[15:0];
            wstrb_d = s_axi_wstrb[1:0];
        end
        if (do_write)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = rf_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        advert_d = rf_advert;
    end

    // Read channel
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (do_read)
        begin
            rvalid_d = 1'b1;
            rdata_d = {16'h0000, rf_rd_data};
            rresp_d = rf_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        // Closed while a response stands or a write owns the register port
        arready_d = !rvalid_d && !(aw_have_d && w_have_d && !bvalid_d);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            advert_q <= ADV_RESET;
        end
        else if (clk_en)
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            advert_q <= advert_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : phy_id_and_autoneg_advert_regs
`default_nettype wire

// File: sim/phy_regs_props.sv
// Checker on the register bank ports.
// Bound into the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module phy_regs_props
    import phy_regs_pkg::*;
(
    // Bus and advertisement
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] advert_q
);
    logic [7:0] ar_q, ar_d, aw_q, aw_d;
    logic [17:0] w_q, w_d;
    always_comb
    begin
        ar_d = s_axi_arvalid && s_axi_arready ? s_axi_araddr : ar_q;
        aw_d = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_q;
        w_d = s_axi_wvalid && s_axi_wready ? {s_axi_wstrb[1:0], s_axi_wdata[15:0]} : w_q;
    end
    always_ff @(posedge aclk)
    begin
        ar_q <= ar_d;
        aw_q <= aw_d;
        w_q <= w_d;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_ADV_RESET: assert property ($rose(aresetn) |-> advert_q == 16'h0101)
        else $error("advert reset value");
    AST_RSVD_ZERO: assert property (advert_q[14] == 1'b0 && advert_q[9] == 1'b0)
        else $error("reserved advert bit set");
    AST_EXT_CAP: assert property (s_axi_rvalid && ar_q == 8'h04 |-> s_axi_rdata[0] == 1'b1)
        else $error("extended capability low");
    AST_ADV_READ: assert property (s_axi_rvalid && ar_q == 8'h10 |-> s_axi_rdata[15:0] == advert_q)
        else $error("advert read differs");
    AST_ADV_WRITE: assert property ($rose(s_axi_bvalid) && aw_q == 8'h10 && w_q[17:16] == 2'b11
        |-> ##[0:3] advert_q == (w_q[15:0] & 16'hBDFF)) else $error("advert write lost");
    AST_RD_SLVERR: assert property (s_axi_rvalid && !(ar_q inside {8'h04, 8'h08, 8'h0C, 8'h10})
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
    AST_WR_SLVERR: assert property ($rose(s_axi_bvalid) && !(aw_q inside {8'h04, 8'h08, 8'h0C, 8'h10})
        |-> s_axi_bresp == 2'h2) else $error("unmapped write");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule : phy_regs_props
bind phy_id_and_autoneg_advert_regs phy_regs_props u_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .advert_q(advert_q)
);
`default_nettype wire

// File: sim/axil_host.sv
// Management host model: AXI4-Lite master with bounded waits.
// Assumes its tasks are called one at a time, just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module axil_host
(
    // Clock
    input wire logic aclk,
    // Write
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input int dly, output logic [1:0] r, output bit ok);
        @(posedge aclk);
        ok = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, dly == 0};
        for (int n = 1; n < 200 && !ok; n++)
        begin
            @(posedge aclk);
            // Released lines show the inverse, not the old value
            if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            ok = s_axi_bready && s_axi_bvalid;
            r = s_axi_bresp;
            s_axi_bready <= n >= dly && !ok;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input int dly, output logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        @(posedge aclk);
        ok = 1'b0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, dly == 0};
        for (int n = 1; n < 200 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            ok = s_axi_rready && s_axi_rvalid;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            s_axi_rready <= n >= dly && !ok;
        end
    endtask : rd
endmodule : axil_host
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the PHY register bank.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import phy_regs_pkg::*;
    localparam logic [3:0] REV = 4'h9;
    logic aclk, aresetn, clk_en;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, s;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] advert_q, adv, v;
    logic [15:0] rst_tab [4] = '{16'h0001, VENDOR_ID_HIGH_RESET,
        {VENDOR_ID_LOW_BITS_RESET, MODEL_RESET, REV}, 16'h0101};
    logic [15:0] corner [3] = '{16'hFFFF, 16'h0000, 16'h0101};
    bit ok;
    int fails, compares;
    phy_id_and_autoneg_advert_regs #(.REVISION(REV)) dut (.*);
    axil_host host (.*);
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
        if (!ok)
        begin
            fails++;
            $display("MISMATCH %0t bus timeout", $time);
            conclude();
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] x, input logic [3:0] st);
        host.wr(a, {16'h0, x}, st, $urandom_range(3), r, ok);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host.rd(a, $urandom_range(3), d, r, ok);
    endtask : rd
    // Byte strobes gate the writable bits only
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] x,
                                          input logic [3:0] st);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}} & 16'hBDFF;
        return (o & ~m) | (x & m);
    endfunction : merge
    task automatic reset_chk;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        adv = 16'h0101;
        for (int i = 0; i < 4; i++)
        begin
            rd(8'h04 + 8'(i * 4));
            chk(d, {16'h0, rst_tab[i]});
        end
    endtask : reset_chk
    initial
    begin
        clk_en = 1'b1;
        ok = 1'b1;
        void'($urandom(33));
        reset_chk();
        // Corners first: all ones, all zeros, then the 100 full duplex setting
        for (int i = 0; i < 24; i++)
        begin
            v = i < 3 ? corner[i] : 16'($urandom);
            s = i < 3 ? 4'hF : 4'($urandom);
            wr(8'h10, v, s);
            adv = merge(adv, v, s);
            rd(8'h10);
            chk(d, {16'h0, adv});
            chk({16'h0, advert_q}, {16'h0, adv});
        end
        // Idle freeze: state must hold while the enable is low
        clk_en <= 1'b0;
        repeat (4) @(posedge aclk);
        chk({16'h0, advert_q}, {16'h0, adv});
        clk_en <= 1'b1;
        rd(8'h10);
        chk(d, {16'h0, adv});
        for (int i = 0; i < 2; i++)
        begin
            v = 16'($urandom);
            wr(8'h08 + 8'(i * 4), v, 4'h3);
            rd(8'h08 + 8'(i * 4));
            chk(d, {16'h0, v});
        end
        wr(8'h04, 16'h0000, 4'h3);
        rd(8'h04);
        chk(d, 32'h1);
        wr(8'h20, 16'hFFFF, 4'hF);
        chk({30'h0, r}, 32'h2);
        rd(8'h20);
        chk(d, 32'h0);
        chk({30'h0, r}, 32'h2);
        rd(8'h10);
        chk(d, {16'h0, adv});
        reset_chk();
        conclude();
    end
endmodule : tb
`default_nettype wire
